/* logic/srs_exec.sv */
// execution unit for pulls, pushes, rotates, returns and subtract-with-borrow
`include "srs_defines.svh"
`default_nettype none
module srs_exec (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// instruction request
	input  wire logic        instr_valid,
	input  wire logic [7:0]  ibyte0,
	input  wire logic [7:0]  ibyte1,
	input  wire logic [7:0]  ibyte2,
	input  wire logic [7:0]  ibyte3,
	output logic             busy,
	output logic             instr_done,
	output logic             instr_illegal,
	// register preload while idle
	input  wire logic        reg_wr_en,
	input  wire logic [3:0]  reg_wr_sel,
	input  wire logic [15:0] reg_wr_data,
	// memory and stack bus, read data valid in the same cycle
	output logic [15:0]      mem_addr,
	output logic             mem_re,
	output logic             mem_we,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// register view
	output logic [15:0]      acc_a,
	output logic [15:0]      acc_b,
	output logic [15:0]      idx_x,
	output logic [15:0]      idx_y,
	output logic [15:0]      dir_page,
	output logic [7:0]       data_bank,
	output logic [7:0]       code_bank,
	output logic [15:0]      stat,
	output logic [15:0]      prog_ctr,
	output logic [15:0]      stack_ptr
);
	import srs_pkg::*;

	srs_state_t  st_q, st_d;            // sequencer state
	srs_kind_t   kind_q, kind_d;        // arithmetic to run
	logic [15:0] rf_q [0:8];            // architectural registers
	logic [15:0] rf_d [0:8];
	logic [15:0] sp_q, sp_d;            // stack pointer
	logic [8:0]  mask_q, mask_d;        // registers still to pop or push
	logic [1:0]  bsel_q, bsel_d;        // byte within current transfer
	logic [3:0]  cyc_q, cyc_d;          // busy cycles so far
	logic [3:0]  tgt_q, tgt_d;          // cycle count that ST_WAIT pads the instruction up to
	logic [15:0] ea_q, ea_d;            // operand address
	logic [15:0] opnd_q, opnd_d;        // memory or immediate operand
	logic [3:0]  acc_q, acc_d;          // accumulator index A or B
	logic [3:0]  rcnt_q, rcnt_d;        // multi-bit rotate count
	logic        ill_q, ill_d;          // illegal opcode seen
	logic [3:0]  lo_idx, hi_idx, cur;   // mask scan results
	logic [1:0]  nb;                    // bytes of current register, or of the memory operand in ST_MRD and ST_MWR
	logic        accb;                  // accumulator B prefix
	logic [7:0]  op, p1, p2;            // opcode and operands after prefix
	logic        acc;                   // request accepted this cycle

	// byte count of a register, follows the width flags
	function automatic logic [1:0] nbytes(input logic [3:0] i, input logic [15:0] ps);
		case (i)
			`SRS_RI_A, `SRS_RI_B: nbytes = ps[`SRS_PS_M] ? 2'd1 : 2'd2;
			`SRS_RI_X, `SRS_RI_Y: nbytes = ps[`SRS_PS_X] ? 2'd1 : 2'd2;
			`SRS_RI_DT, `SRS_RI_PG: nbytes = 2'd1;
			default: nbytes = 2'd2;
		endcase
	endfunction

	// map the selection byte onto register indexes; code bank only for pushes
	function automatic logic [8:0] selmap(input logic [7:0] s, input logic with_pg);
		selmap = {s[6] & with_pg, 1'b0, s[7], s[5:0]};
	endfunction

	// prefix decode, shared with the assertions
	always_comb begin
		accb = (ibyte0 == `SRS_OP_PFX_B);
		op   = accb ? ibyte1 : ibyte0;
		p1   = accb ? ibyte2 : ibyte1;
		p2   = accb ? ibyte3 : ibyte2;
		acc  = (st_q == ST_IDLE) && instr_valid;
	end

	// lowest set bit pops first, highest pushes first so the two mirror
	always_comb begin
		lo_idx = 4'h0;
		hi_idx = 4'h0;
		for (int i = 8; i >= 0; i--) begin
			if (mask_q[i]) lo_idx = 4'(i);
		end
		for (int i = 0; i <= 8; i++) begin
			if (mask_q[i]) hi_idx = 4'(i);
		end
		cur = (st_q == ST_PUSH) ? hi_idx : lo_idx;
		nb  = ((st_q == ST_MRD) || (st_q == ST_MWR)) ? nbytes(`SRS_RI_A, rf_q[`SRS_RI_PS]) :
			nbytes(cur, rf_q[`SRS_RI_PS]);
	end

	// next-state logic of the whole sequencer
	always_comb begin
		logic [16:0] t16;
		logic [8:0]  t8;
		logic [31:0] r32;
		logic [15:0] r16, a, r;
		logic        w8, c;
		t16 = 17'h0_0000;
		t8  = 9'h000;
		r32 = 32'h0000_0000;
		r16 = 16'h0000;
		a   = rf_q[acc_q];
		r   = a;
		w8  = rf_q[`SRS_RI_PS][`SRS_PS_M];
		c   = rf_q[`SRS_RI_PS][`SRS_PS_C];
		st_d = st_q;
		kind_d = kind_q;
		for (int i = 0; i <= 8; i++) rf_d[i] = rf_q[i];
		sp_d = sp_q;
		mask_d = mask_q;
		bsel_d = bsel_q;
		cyc_d = (st_q == ST_IDLE) ? 4'h0 : cyc_q + 4'h1;
		tgt_d = tgt_q;
		ea_d = ea_q;
		opnd_d = opnd_q;
		acc_d = acc_q;
		rcnt_d = rcnt_q;
		ill_d = 1'b0;
		mem_addr = 16'h0000;
		mem_re = 1'b0;
		mem_we = 1'b0;
		mem_wdata = 8'h00;
		instr_done = 1'b0;
		case (st_q)
			ST_IDLE: begin
				// preload is ignored while a request is taken
				if (reg_wr_en && !instr_valid) begin
					if (reg_wr_sel == `SRS_RI_SP) sp_d = reg_wr_data;
					else if (reg_wr_sel <= `SRS_RI_PG) rf_d[reg_wr_sel] = reg_wr_data;
				end
				if (instr_valid) begin
					acc_d = accb ? `SRS_RI_B : `SRS_RI_A;
					bsel_d = 2'd0;
					kind_d = K_NONE;
					st_d = ST_POP;
					tgt_d = `SRS_CYC_MIN;
					if (ibyte0 == `SRS_OP_PFX_RLA && ibyte1 == `SRS_OP_RLA) begin
						acc_d = `SRS_RI_A;
						rcnt_d = ibyte2[3:0];
						kind_d = K_RLA;
						tgt_d = `SRS_CYC_RLA;
						st_d = ST_EXEC;
					end else begin
						case (op)
							`SRS_OP_ROL_D, `SRS_OP_ROL_DX,
							`SRS_OP_ROR_D, `SRS_OP_ROR_DX: begin
								kind_d = (op[6]) ? K_ROR : K_ROL;
								ea_d = rf_q[`SRS_RI_DP] + {8'h00, p1} + (op[4] ? rf_q[`SRS_RI_X] : 16'h0000);
								tgt_d = `SRS_CYC_ROT;
								st_d = ST_MRD;
							end
							`SRS_OP_SBC_IMM: begin
								kind_d = K_SBC;
								opnd_d = {p2, p1};
								tgt_d = `SRS_CYC_SBC_IMM + (accb ? `SRS_CYC_B_EXTRA : 4'h0);
								st_d = ST_EXEC;
							end
							`SRS_OP_SBC_DIR: begin
								kind_d = K_SBC;
								ea_d = rf_q[`SRS_RI_DP] + {8'h00, p1};
								tgt_d = `SRS_CYC_SBC_DIR + (accb ? `SRS_CYC_B_EXTRA : 4'h0);
								st_d = ST_MRD;
							end
							`SRS_OP_RTI: begin
								mask_d = `SRS_MASK_RTI;
								tgt_d = `SRS_CYC_RTI;
							end
							`SRS_OP_RTL: begin
								mask_d = `SRS_MASK_RTL;
								tgt_d = `SRS_CYC_RTL;
							end
							`SRS_OP_RTS: begin
								mask_d = `SRS_MASK_RTS;
								tgt_d = `SRS_CYC_RTS;
							end
							`SRS_OP_PLY: begin
								mask_d = `SRS_MASK_PLY;
								tgt_d = `SRS_CYC_PLY;
							end
							`SRS_OP_PSH: begin
								mask_d = selmap(p1, 1'b1);
								st_d = (p1 == 8'h00) ? ST_WAIT : ST_PUSH;
							end
							`SRS_OP_PUL: begin
								mask_d = selmap(p1, 1'b0);
								st_d = (selmap(p1, 1'b0) == 9'h000) ? ST_WAIT : ST_POP;
							end
							default: begin
								ill_d = 1'b1;
								st_d = ST_WAIT;
							end
						endcase
					end
				end
			end
			ST_POP: begin
				mem_re = 1'b1;
				mem_addr = sp_q + 16'h0001;
				sp_d = sp_q + 16'h0001;
				if (bsel_q == 2'd0) rf_d[cur][7:0] = mem_rdata;
				else rf_d[cur][15:8] = mem_rdata;
				bsel_d = bsel_q + 2'd1;
				if (bsel_q + 2'd1 == nb) begin
					mask_d[cur] = 1'b0;
					bsel_d = 2'd0;
					if ((mask_q & ~(9'h001 << cur)) == 9'h000) st_d = ST_WAIT;
				end
			end
			ST_PUSH: begin
				mem_we = 1'b1;
				mem_addr = sp_q;
				sp_d = sp_q - 16'h0001;
				mem_wdata = (nb == 2'd2 && bsel_q == 2'd0) ? rf_q[cur][15:8] : rf_q[cur][7:0];
				bsel_d = bsel_q + 2'd1;
				if (bsel_q + 2'd1 == nb) begin
					mask_d[cur] = 1'b0;
					bsel_d = 2'd0;
					if ((mask_q & ~(9'h001 << cur)) == 9'h000) st_d = ST_WAIT;
				end
			end
			ST_MRD: begin
				// operand fetch, one byte per cycle
				mem_re = 1'b1;
				mem_addr = ea_q + {14'h0000, bsel_q};
				if (bsel_q == 2'd0) opnd_d = {8'h00, mem_rdata};
				else opnd_d[15:8] = mem_rdata;
				bsel_d = bsel_q + 2'd1;
				if (bsel_q + 2'd1 == nb) begin
					bsel_d = 2'd0;
					st_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				st_d = ST_WAIT;
				case (kind_q)
					K_ROL: begin
						// carry into bit 0, top bit out
						r = w8 ? {opnd_q[15:8], opnd_q[6:0], c} : {opnd_q[14:0], c};
						c = w8 ? opnd_q[7] : opnd_q[15];
						opnd_d = r;
						st_d = ST_MWR;
					end
					K_ROR: begin
						// carry into top bit, bit 0 out
						r = w8 ? {opnd_q[15:8], c, opnd_q[7:1]} : {c, opnd_q[15:1]};
						c = opnd_q[0];
						opnd_d = r;
						st_d = ST_MWR;
					end
					K_SBC: begin
						t16 = {1'b0, a} - {1'b0, opnd_q} - {16'h0000, ~c};
						t8 = {1'b0, a[7:0]} - {1'b0, opnd_q[7:0]} - {8'h00, ~c};
						r = w8 ? {a[15:8], t8[7:0]} : t16[15:0];
						c = w8 ? ~t8[8] : ~t16[16];
						rf_d[`SRS_RI_PS][`SRS_PS_V] = w8 ? ((a[7] ^ opnd_q[7]) & (a[7] ^ r[7])) :
							((a[15] ^ opnd_q[15]) & (a[15] ^ r[15]));
						rf_d[acc_q] = r;
					end
					K_RLA: begin
						// doubled word shifted, upper half is the rotate
						r32 = {a, a} << rcnt_q;
						r16 = {a[7:0], a[7:0]} << rcnt_q[2:0];
						r = w8 ? {a[15:8], r16[15:8]} : r32[31:16];
						rf_d[acc_q] = r;
					end
					default: r = a;
				endcase
				if (kind_q != K_NONE) begin
					rf_d[`SRS_RI_PS][`SRS_PS_C] = c;
					rf_d[`SRS_RI_PS][`SRS_PS_N] = w8 ? r[7] : r[15];
					rf_d[`SRS_RI_PS][`SRS_PS_Z] = w8 ? (r[7:0] == 8'h00) : (r == 16'h0000);
				end
			end
			ST_MWR: begin
				// rotate result written back, low byte first
				mem_we = 1'b1;
				mem_addr = ea_q + {14'h0000, bsel_q};
				mem_wdata = (bsel_q == 2'd0) ? opnd_q[7:0] : opnd_q[15:8];
				bsel_d = bsel_q + 2'd1;
				if (bsel_q + 2'd1 == nb) begin
					bsel_d = 2'd0;
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// pad to the documented cycle count
				if (cyc_q + 4'h1 >= tgt_q) begin
					instr_done = 1'b1;
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			kind_q <= K_NONE;
			for (int i = 0; i <= 8; i++) rf_q[i] <= `SRS_RST_REG;
			sp_q <= `SRS_RST_SP;
			mask_q <= 9'h000;
			bsel_q <= 2'd0;
			cyc_q <= 4'h0;
			tgt_q <= `SRS_CYC_MIN;
			ea_q <= 16'h0000;
			opnd_q <= 16'h0000;
			acc_q <= `SRS_RI_A;
			rcnt_q <= 4'h0;
			ill_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			for (int i = 0; i <= 8; i++) rf_q[i] <= rf_d[i];
			sp_q <= sp_d;
			mask_q <= mask_d;
			bsel_q <= bsel_d;
			cyc_q <= cyc_d;
			tgt_q <= tgt_d;
			ea_q <= ea_d;
			opnd_q <= opnd_d;
			acc_q <= acc_d;
			rcnt_q <= rcnt_d;
			ill_q <= ill_d;
		end
	end

	// register view, all from flops
	assign busy = (st_q != ST_IDLE);
	assign instr_illegal = ill_q;
	assign acc_a = rf_q[`SRS_RI_A];
	assign acc_b = rf_q[`SRS_RI_B];
	assign idx_x = rf_q[`SRS_RI_X];
	assign idx_y = rf_q[`SRS_RI_Y];
	assign dir_page = rf_q[`SRS_RI_DP];
	assign data_bank = rf_q[`SRS_RI_DT][7:0];
	assign code_bank = rf_q[`SRS_RI_PG][7:0];
	assign stat = rf_q[`SRS_RI_PS];
	assign prog_ctr = rf_q[`SRS_RI_PC];
	assign stack_ptr = sp_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_acc(logic [7:0] o);
		acc && !accb && op == o;
	endsequence

	chk_pull_y_len: assert property (s_acc(`SRS_OP_PLY) |-> ##5
		(instr_done && stack_ptr == $past(stack_ptr, 5) + (stat[`SRS_PS_X] ? 16'h0001 : 16'h0002)))
		else $error("pull Y stack step wrong");
	chk_push_sp_step: assert property (st_q == ST_PUSH |=> sp_q == $past(sp_q) - 16'h0001)
		else $error("push did not decrement stack");
	chk_restore_no_bank: assert property (s_acc(`SRS_OP_PUL) |=> !mask_q[8])
		else $error("restore selected code bank");
	chk_rla_len: assert property (acc && ibyte0 == `SRS_OP_PFX_RLA && ibyte1 == `SRS_OP_RLA |-> ##6 instr_done)
		else $error("multi rotate not 6 cycles");
	chk_rol_len: assert property (s_acc(`SRS_OP_ROL_D) |-> ##7 instr_done)
		else $error("rotate left not 7 cycles");
	chk_ror_len: assert property (s_acc(`SRS_OP_ROR_DX) |-> ##7 instr_done)
		else $error("rotate right not 7 cycles");
	chk_rti_len: assert property (s_acc(`SRS_OP_RTI) |-> ##11 instr_done)
		else $error("interrupt return not 11 cycles");
	chk_rtl_len: assert property (s_acc(`SRS_OP_RTL) |-> ##8 (instr_done && stack_ptr == $past(stack_ptr, 8) + 16'h0003))
		else $error("long return length or pops wrong");
	chk_rts_bank: assert property (s_acc(`SRS_OP_RTS) |-> ##5 (instr_done && code_bank == $past(code_bank, 5)))
		else $error("short return touched bank or length");
	chk_sbc_len: assert property (s_acc(`SRS_OP_SBC_DIR) |-> ##4 instr_done)
		else $error("subtract direct not 4 cycles");
	chk_zero_flag: assert property (st_q == ST_EXEC && kind_q == K_SBC && !stat[`SRS_PS_M] |=>
		stat[`SRS_PS_Z] == (rf_q[acc_q] == 16'h0000))
		else $error("zero flag does not match result");
endmodule // srs_exec
`default_nettype wire

/* shared/srs_defines.svh */
// opcode, cycle-count, status-bit and register-index constants for the stack/rotate/subtract unit
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH
// opcodes
`define SRS_OP_PFX_B   8'h42
`define SRS_OP_PFX_RLA 8'h89
`define SRS_OP_RLA     8'h49
`define SRS_OP_ROL_D   8'h26
`define SRS_OP_ROL_DX  8'h36
`define SRS_OP_ROR_D   8'h66
`define SRS_OP_ROR_DX  8'h76
`define SRS_OP_RTI     8'h40
`define SRS_OP_RTL     8'h6B
`define SRS_OP_RTS     8'h60
`define SRS_OP_SBC_IMM 8'hE9
`define SRS_OP_SBC_DIR 8'hE5
`define SRS_OP_PLY     8'h7A
`define SRS_OP_PSH     8'hEB
`define SRS_OP_PUL     8'hFB
// total cycles per instruction
`define SRS_CYC_RLA     4'h6
`define SRS_CYC_ROT     4'h7
`define SRS_CYC_RTI     4'hB
`define SRS_CYC_RTL     4'h8
`define SRS_CYC_RTS     4'h5
`define SRS_CYC_SBC_DIR 4'h4
`define SRS_CYC_SBC_IMM 4'h2
`define SRS_CYC_B_EXTRA 4'h2
`define SRS_CYC_PLY     4'h5
`define SRS_CYC_MIN     4'h1
// status register bit positions
`define SRS_PS_C 0
`define SRS_PS_Z 1
`define SRS_PS_X 4
`define SRS_PS_M 5
`define SRS_PS_V 6
`define SRS_PS_N 7
// register file index, also the pop order
`define SRS_RI_A  4'h0
`define SRS_RI_B  4'h1
`define SRS_RI_X  4'h2
`define SRS_RI_Y  4'h3
`define SRS_RI_DP 4'h4
`define SRS_RI_DT 4'h5
`define SRS_RI_PS 4'h6
`define SRS_RI_PC 4'h7
`define SRS_RI_PG 4'h8
`define SRS_RI_SP 4'h9
// pop masks for returns and pull-Y
`define SRS_MASK_RTI 9'h1C0
`define SRS_MASK_RTL 9'h180
`define SRS_MASK_RTS 9'h080
`define SRS_MASK_PLY 9'h008
// reset values
`define SRS_RST_SP  16'h0FFF
`define SRS_RST_REG 16'h0000
`endif

/* shared/srs_pkg.sv */
// types shared by the stack/rotate/subtract unit
`default_nettype none
package srs_pkg;
	// sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_POP, ST_PUSH, ST_MRD, ST_EXEC, ST_MWR, ST_WAIT} srs_state_t;
	// arithmetic kind carried to the execute step
	typedef enum logic [2:0] {K_NONE, K_ROL, K_ROR, K_SBC, K_RLA} srs_kind_t;
endpackage
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the stack/rotate/subtract execution unit
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// clock, reset, request and preload drives
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        instr_valid = 1'b0;
	logic [7:0]  ibyte0 = 8'h00, ibyte1 = 8'h00, ibyte2 = 8'h00, ibyte3 = 8'h00;
	logic        reg_wr_en = 1'b0;
	logic [3:0]  reg_wr_sel = 4'h0;
	logic [15:0] reg_wr_data = 16'h0000;
	// design outputs
	logic        busy, instr_done, instr_illegal, mem_re, mem_we;
	logic [15:0] mem_addr, acc_a, acc_b, idx_x, idx_y, dir_page, stat, prog_ctr, stack_ptr;
	logic [7:0]  mem_wdata, mem_rdata, data_bank, code_bank;
	// byte memory standing in for the stack and data space
	logic [7:0]  mem [0:65535];
	logic [15:0] cyc = 16'h0000;
	int          errors = 0;
	int          total_checks = 0;

	always #5 clk_sys = ~clk_sys;

	// undriven read data keeps moving so a read outside a strobe cannot pass by luck
	assign mem_rdata = (mem_re === 1'b1) ? mem[mem_addr] : ~cyc[7:0];

	// byte writes land on the rising edge
	always @(posedge clk_sys) begin
		if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
	end

	srs_exec srs_exec_i (.clk_sys, .rstn, .instr_valid, .ibyte0, .ibyte1, .ibyte2, .ibyte3, .busy,
		.instr_done, .instr_illegal, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .mem_addr, .mem_re,
		.mem_we, .mem_wdata, .mem_rdata, .acc_a, .acc_b, .idx_x, .idx_y, .dir_page, .data_bank,
		.code_bank, .stat, .prog_ctr, .stack_ptr);

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// one comparison of a 16-bit result
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		total_checks++;
		if (got !== want) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask

	// hang guard at 3000 cycles, well above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 16'h0001;
		if (cyc == 16'h0BB8) begin
			errors++;
			end_sim();
		end
	end

	task automatic rst();
		rstn = 1'b0;
		repeat (16) @(posedge clk_sys);
		#1 rstn = 1'b1;
	endtask

	// preload while idle; a spare edge keeps the strobe low between two calls
	task automatic wr(input logic [3:0] sel, input logic [15:0] d);
		reg_wr_sel = sel;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(posedge clk_sys);
		#1 reg_wr_en = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	// issue one instruction and count cycles from the taking edge to done
	task automatic run(input logic [7:0] b0, b1, b2, b3, input logic [15:0] n_want);
		int n;
		{ibyte0, ibyte1, ibyte2, ibyte3} = {b0, b1, b2, b3};
		instr_valid = 1'b1;
		@(posedge clk_sys);
		#1 instr_valid = 1'b0;
		n = 1;
		while (instr_done !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk(16'(n), n_want);
		@(posedge clk_sys);
		#1;
	endtask

	task automatic t_reset();
		rst();
		chk(stack_ptr, 16'h0FFF);
		chk({15'h0000, busy}, 16'h0000);
		chk(acc_a, 16'h0000);
		chk(stat, 16'h0000);
	endtask

	// returns chained on one stack, each popping above the last
	task automatic t_ret();
		rst();
		wr(4'h9, 16'h0200);
		wr(4'h8, 16'h0012);
		{mem[16'h0202], mem[16'h0201]} = 16'h5634;
		run(8'h60, 8'h00, 8'h00, 8'h00, 16'h0005);
		chk(prog_ctr, 16'h5634);
		chk(stack_ptr, 16'h0202);
		chk({8'h00, code_bank}, 16'h0012);
		{mem[16'h0203], mem[16'h0204], mem[16'h0205]} = {8'h78, 8'h9A, 8'h3C};
		run(8'h6B, 8'h00, 8'h00, 8'h00, 16'h0008);
		chk(prog_ctr, 16'h9A78);
		chk({8'h00, code_bank}, 16'h003C);
		chk(stack_ptr, 16'h0205);
		{mem[16'h0206], mem[16'h0207], mem[16'h0208], mem[16'h0209]} = 32'h4300_CDAB;
		mem[16'h020A] = 8'h5E;
		run(8'h40, 8'h00, 8'h00, 8'h00, 16'h000B);
		chk(stat, 16'h0043);
		chk(prog_ctr, 16'hABCD);
		chk({8'h00, code_bank}, 16'h005E);
		chk(stack_ptr, 16'h020A);
	endtask

	// pull of Y in both index widths; the 8-bit pull keeps the high byte
	task automatic t_ply();
		rst();
		wr(4'h9, 16'h0500);
		wr(4'h3, 16'hBEEF);
		{mem[16'h0502], mem[16'h0501]} = 16'h2211;
		run(8'h7A, 8'h00, 8'h00, 8'h00, 16'h0005);
		chk(idx_y, 16'h2211);
		chk(stack_ptr, 16'h0502);
		wr(4'h6, 16'h0010);
		mem[16'h0503] = 8'h77;
		run(8'h7A, 8'h00, 8'h00, 8'h00, 16'h0005);
		chk(idx_y, 16'h2277);
		chk(stack_ptr, 16'h0503);
	endtask

	// rotate of the word at 0112; direct forms use offset 12, indexed use 10 plus X=2
	task automatic rot(input logic [7:0] op, k, input logic [15:0] st, v, ev, es);
		wr(4'h6, st);
		{mem[16'h0113], mem[16'h0112]} = v;
		run(op, k, 8'h00, 8'h00, 16'h0007);
		chk({mem[16'h0113], mem[16'h0112]}, ev);
		chk(stat, es);
	endtask

	task automatic t_rot();
		rst();
		wr(4'h4, 16'h0100);
		wr(4'h2, 16'h0002);
		rot(8'h26, 8'h12, 16'h0001, 16'h8001, 16'h0003, 16'h0001);
		rot(8'h36, 8'h10, 16'h0000, 16'h4000, 16'h8000, 16'h0080);
		rot(8'h66, 8'h12, 16'h0001, 16'h0002, 16'h8001, 16'h0080);
		rot(8'h76, 8'h10, 16'h0000, 16'h0001, 16'h0000, 16'h0003);
		// 8-bit width: only the low byte moves, the byte above stays put
		rot(8'h26, 8'h12, 16'h0021, 16'h55C0, 16'h5581, 16'h00A1);
	endtask

	// borrow in and out, overflow, zero, and the accumulator B prefix
	task automatic t_sbc();
		rst();
		wr(4'h0, 16'h1234);
		wr(4'h6, 16'h0001);
		run(8'hE9, 8'h35, 8'h02, 8'h00, 16'h0002);
		chk(acc_a, 16'h0FFF);
		chk(stat, 16'h0001);
		run(8'hE9, 8'hFF, 8'h0F, 8'h00, 16'h0002);
		chk(acc_a, 16'h0000);
		chk(stat, 16'h0003);
		wr(4'h1, 16'h8000);
		wr(4'h6, 16'h0000);
		run(8'h42, 8'hE9, 8'h01, 8'h00, 16'h0004);
		chk(acc_b, 16'h7FFE);
		chk(stat, 16'h0041);
		wr(4'h4, 16'h0100);
		wr(4'h6, 16'h0001);
		{mem[16'h0121], mem[16'h0120]} = 16'h0001;
		run(8'hE5, 8'h20, 8'h00, 8'h00, 16'h0004);
		chk(acc_a, 16'hFFFF);
		chk(stat, 16'h0080);
		// accumulator B direct form with a borrow in, then 8-bit immediate
		run(8'h42, 8'hE5, 8'h20, 8'h00, 16'h0006);
		chk(acc_b, 16'h7FFC);
		chk(stat, 16'h0001);
		wr(4'h6, 16'h0021);
		run(8'hE9, 8'h0F, 8'h00, 8'h00, 16'h0002);
		chk(acc_a, 16'hFFF0);
		chk(stat, 16'h00A1);
	endtask

	// multi-bit rotate in 16-bit and 8-bit data width
	task automatic t_rla();
		rst();
		wr(4'h0, 16'h8001);
		run(8'h89, 8'h49, 8'h04, 8'h00, 16'h0006);
		chk(acc_a, 16'h0018);
		chk(stat, 16'h0000);
		wr(4'h6, 16'h0020);
		wr(4'h0, 16'h1281);
		run(8'h89, 8'h49, 8'h0B, 8'h00, 16'h0006);
		chk(acc_a, 16'h120C);
		chk(stat, 16'h0020);
	endtask

	// push with code bank selected, then restore with the same mask skipping it
	task automatic t_stk();
		rst();
		wr(4'h9, 16'h0600);
		wr(4'h0, 16'h1122);
		wr(4'h2, 16'h3344);
		wr(4'h8, 16'h0055);
		run(8'hEB, 8'h45, 8'h00, 8'h00, 16'h0006);
		chk({mem[16'h0600], mem[16'h05FF]}, 16'h5533);
		chk({mem[16'h05FE], mem[16'h05FD]}, 16'h4411);
		chk({8'h00, mem[16'h05FC]}, 16'h0022);
		chk(stack_ptr, 16'h05FB);
		wr(4'h0, 16'h0000);
		wr(4'h2, 16'h0000);
		wr(4'h8, 16'h0000);
		run(8'hFB, 8'h45, 8'h00, 8'h00, 16'h0005);
		chk(acc_a, 16'h1122);
		chk(idx_x, 16'h3344);
		chk({8'h00, code_bank}, 16'h0000);
		chk(stack_ptr, 16'h05FF);
		// direct page and data bank round trip
		wr(4'h4, 16'h6677);
		wr(4'h5, 16'h0088);
		run(8'hEB, 8'h30, 8'h00, 8'h00, 16'h0004);
		chk({mem[16'h05FE], mem[16'h05FD]}, 16'h6677);
		chk({8'h00, mem[16'h05FF]}, 16'h0088);
		wr(4'h4, 16'h0000);
		wr(4'h5, 16'h0000);
		run(8'hFB, 8'h30, 8'h00, 8'h00, 16'h0004);
		chk(dir_page, 16'h6677);
		chk({8'h00, data_bank}, 16'h0088);
		chk(stack_ptr, 16'h05FF);
	endtask

	// unknown opcode: illegal and done pulse together in the one busy cycle
	task automatic t_ill();
		{ibyte0, ibyte1, ibyte2, ibyte3} = 32'h0000_0000;
		instr_valid = 1'b1;
		@(posedge clk_sys);
		#1 instr_valid = 1'b0;
		chk({14'h0000, instr_illegal, instr_done}, 16'h0003);
		@(posedge clk_sys);
		#1 chk({14'h0000, instr_illegal, busy}, 16'h0000);
	endtask

	initial begin
		t_reset();
		t_ret();
		t_ply();
		t_rot();
		t_sbc();
		t_rla();
		t_stk();
		t_ill();
		end_sim();
	end
endmodule // tb
`default_nettype wire
